// File: src/move_or_pkg.sv
package move_or_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int REG_W = 5;
  localparam int NUM_REGS = 32;
  localparam int NUM_IDX = 4;
  localparam int FLAG_W = 4;
  localparam int BANK_W = 2;
  localparam int STK_W = ADDR_W + FLAG_W + 1 + BANK_W;
  localparam int PADDR_W = 12;

  // apb register byte offsets
  localparam logic [PADDR_W-1:0] OFS_CMD = 12'h000;
  localparam logic [PADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [PADDR_W-1:0] OFS_CCR = 12'h008;
  localparam logic [PADDR_W-1:0] OFS_REGSEL = 12'h00C;
  localparam logic [PADDR_W-1:0] OFS_REGDATA = 12'h010;
  localparam logic [PADDR_W-1:0] OFS_IDX0 = 12'h014;
  localparam logic [PADDR_W-1:0] OFS_PC = 12'h024;
  localparam logic [PADDR_W-1:0] OFS_STACK = 12'h028;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_RA_LSB = 3;
  localparam int CMD_RB_LSB = 8;
  localparam int CMD_IDX_LSB = 13;
  localparam int CMD_AM_LSB = 15;
  localparam int CMD_IMM_LSB = 17;
  localparam int CMD_F_LSB = 25;
  localparam int CMD_S_BIT = 28;
  localparam int CMD_G_LSB = 29;
  localparam int CMD_RF_BIT = 31;

  // status word fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_TAKEN_BIT = 2;
  localparam int ST_SP_LSB = 8;
  localparam int ST_CCR_LSB = 16;

  // condition_code_register layout, also the apb CONDITION_CODE_REGISTER word
  localparam int FLAG_Z = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 2;
  localparam int FLAG_N = 3;
  localparam int CCR_GIE_BIT = 4;
  localparam int CCR_BANK_LSB = 5;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
  localparam logic [BANK_W-1:0] BANK_RESET = 2'h0;

  // transceiver_status_register bit positions
  localparam int TSR_RA_BIT = 0;
  localparam int TSR_RE_BIT = 1;
  localparam int TSR_DAV_BIT = 2;
  localparam int TSR_TFF_BIT = 3;

  // flag selector codes
  localparam logic [2:0] F_Z = 3'h0;
  localparam logic [2:0] F_C = 3'h1;
  localparam logic [2:0] F_V = 3'h2;
  localparam logic [2:0] F_N = 3'h3;
  localparam logic [2:0] F_RA = 3'h4;
  localparam logic [2:0] F_RE = 3'h5;
  localparam logic [2:0] F_DAV = 3'h6;
  localparam logic [2:0] F_TFF = 3'h7;

  // interrupt-enable action on a taken return
  localparam logic [1:0] G_KEEP = 2'h0;
  localparam logic [1:0] G_RESTORE = 2'h1;
  localparam logic [1:0] G_SET = 2'h2;
  localparam logic [1:0] G_CLEAR = 2'h3;

  // stack entry layout
  localparam int STK_PC_LSB = 0;
  localparam int STK_FLAG_LSB = 16;
  localparam int STK_GIE_BIT = 20;
  localparam int STK_BANK_LSB = 21;

  localparam logic [REG_W-1:0] ACC_MAIN_IDX = 5'h00;
  localparam logic [REG_W-1:0] ACC_ALT_IDX = 5'h10;
  localparam logic [1:0] IZ_SEL = 2'h3;
  localparam logic [ADDR_W-1:0] PC_STEP = 16'h0001;

  typedef enum logic [2:0] {
    OP_MOVE_MR = 3'h0,
    OP_MOVE_RM = 3'h1,
    OP_MOVE_RR = 3'h2,
    OP_OR_IMM = 3'h3,
    OP_ORA_R = 3'h4,
    OP_ORA_M = 3'h5,
    OP_CONDITIONAL_RETURN_OP = 3'h6,
    OP_NOP = 3'h7
  } op_e;

  typedef enum logic [1:0] {
    AM_INDEXED = 2'h0,
    AM_REGREL = 2'h1,
    AM_IMMREL = 2'h2,
    AM_RSVD = 2'h3
  } am_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_MEM = 2'b11,
    S_POP = 2'b10
  } state_e;
endpackage

// File: src/addr_stack_mem.sv
`timescale 1ns/100ps
module addr_stack_mem #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdEn,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
  end

  // read data registered, valid the cycle after rdEn
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rdData <= '0;
    else if (rdEn)
      rdData <= mem[rdAddr];
  end
endmodule // addr_stack_mem

// File: src/move_or_condreturn_exec.sv
`timescale 1ns/100ps
module move_or_condreturn_exec import move_or_pkg::*; #(
  parameter int STACK_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] dmAddr,
  output logic [DATA_W-1:0] dmWdata,
  output logic dmRead,
  output logic dmWrite,
  input wire logic [DATA_W-1:0] dmRdata,
  input wire logic dmAck,
  input wire logic [7:0] trxStatus,
  output logic globalInterruptEnable
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  generate
    if (STACK_DEPTH < 2 || STACK_DEPTH > 128 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("STACK_DEPTH must be a power of two from 2 to 128");
    end
  endgenerate

  state_e state_r, state_nxt;
  op_e op_r, op_nxt;
  am_e am_r, am_nxt;
  logic [REG_W-1:0] regA_r, regA_nxt, regB_r, regB_nxt, regSel_r, regSel_nxt;
  logic [1:0] idxSel_r, idxSel_nxt, g_r, g_nxt;
  logic [DATA_W-1:0] imm_r, imm_nxt;
  logic [2:0] fsel_r, fsel_nxt;
  logic sval_r, sval_nxt, rf_r, rf_nxt, err_r, err_nxt, taken_r, taken_nxt;
  logic [FLAG_W-1:0] flags_r, flags_nxt;
  logic gie_r, gie_nxt;
  logic [BANK_W-1:0] bank_r, bank_nxt;
  logic [ADDR_W-1:0] pc_r, pc_nxt;
  logic [SP_W:0] sp_r, sp_nxt, spDec;
  logic [ADDR_W-1:0] idx_r [NUM_IDX];
  logic [ADDR_W-1:0] idx_nxt [NUM_IDX];
  logic [DATA_W-1:0] regs_r [NUM_REGS];
  logic [DATA_W-1:0] regs_nxt [NUM_REGS];
  logic [ADDR_W-1:0] dmAddr_r, dmAddr_nxt;
  logic [DATA_W-1:0] dmWdata_r, dmWdata_nxt;
  logic dmRead_r, dmRead_nxt, dmWrite_r, dmWrite_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic busy, apbWrite, mapped, stkWr, stkRd, flagVal, cond, stackFull;
  logic [PADDR_W-1:0] idxOfs;
  logic [DATA_W-1:0] acc, orRes;
  logic [ADDR_W-1:0] ea;
  logic [STK_W-1:0] stkQ, stkWdata;

  assign busy = (state_r != S_IDLE);
  assign spDec = sp_r - 1'b1;
  assign stackFull = sp_r[SP_W];
  assign idxOfs = paddr - OFS_IDX0;
  assign apbWrite = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign stkWdata = {bank_r, gie_r, flags_r, pc_r};

  addr_stack_mem #(.WIDTH(STK_W), .DEPTH(STACK_DEPTH)) uStack (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wrEn(stkWr),
    .wrAddr(sp_r[SP_W-1:0]),
    .wrData(stkWdata),
    .rdEn(stkRd),
    .rdAddr(spDec[SP_W-1:0]),
    .rdData(stkQ)
  );

  // operands, effective address and flag selection
  always_comb
  begin
    acc = regs_r[bank_r[0] ? ACC_ALT_IDX : ACC_MAIN_IDX];
    case (am_r)
      AM_REGREL: ea = idx_r[idxSel_r] + {8'h00, acc};
      AM_IMMREL: ea = idx_r[IZ_SEL] + {8'h00, imm_r};
      default: ea = idx_r[idxSel_r];
    endcase
    case (fsel_r)
      F_Z: flagVal = flags_r[FLAG_Z];
      F_C: flagVal = flags_r[FLAG_C];
      F_V: flagVal = flags_r[FLAG_V];
      F_N: flagVal = flags_r[FLAG_N];
      F_RA: flagVal = trxStatus[TSR_RA_BIT];
      F_RE: flagVal = trxStatus[TSR_RE_BIT];
      F_DAV: flagVal = trxStatus[TSR_DAV_BIT];
      F_TFF: flagVal = trxStatus[TSR_TFF_BIT];
      default: flagVal = 1'b0;
    endcase
    cond = (flagVal == sval_r);
    orRes = (op_r == OP_OR_IMM) ? (regs_r[regA_r] | imm_r) : (regs_r[regA_r] | acc);
  end

  // apb slave answer, decided in the setup cycle
  always_comb
  begin
    pready_nxt = psel & ~penable;
    prdata_nxt = prdata_r;
    mapped = 1'b1;
    if (paddr >= OFS_IDX0 && paddr < OFS_PC)
      prdata_nxt = {16'h0000, idx_r[idxOfs[3:2]]};
    else
    begin
      case (paddr)
        OFS_CMD: prdata_nxt = {rf_r, g_r, sval_r, fsel_r, imm_r, am_r, idxSel_r, regB_r, regA_r, op_r};
        OFS_STATUS: prdata_nxt = {9'h000, bank_r, gie_r, flags_r, 8'(sp_r), 5'h00, taken_r, err_r, busy};
        OFS_CCR: prdata_nxt = {25'h0000000, bank_r, gie_r, flags_r};
        OFS_REGSEL: prdata_nxt = {27'h0000000, regSel_r};
        OFS_REGDATA: prdata_nxt = {24'h000000, regs_r[regSel_r]};
        OFS_PC: prdata_nxt = {16'h0000, pc_r};
        OFS_STACK: prdata_nxt = {24'h000000, 8'(sp_r)};
        default: mapped = 1'b0;
      endcase
    end
    if (paddr[1:0] != 2'h0)
      mapped = 1'b0;
    if (!mapped)
      prdata_nxt = 32'h00000000;
    // writes refused while an instruction runs or onto a full stack
    pslverr_nxt = psel & ~penable & (~mapped | (pwrite & (busy | paddr == OFS_STATUS
                  | (paddr == OFS_STACK & stackFull))));
  end

  // instruction engine
  always_comb
  begin
    state_nxt = state_r;
    op_nxt = op_r;
    am_nxt = am_r;
    regA_nxt = regA_r;
    regB_nxt = regB_r;
    regSel_nxt = regSel_r;
    idxSel_nxt = idxSel_r;
    imm_nxt = imm_r;
    fsel_nxt = fsel_r;
    sval_nxt = sval_r;
    g_nxt = g_r;
    rf_nxt = rf_r;
    err_nxt = err_r;
    taken_nxt = taken_r;
    flags_nxt = flags_r;
    gie_nxt = gie_r;
    bank_nxt = bank_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    idx_nxt = idx_r;
    regs_nxt = regs_r;
    dmAddr_nxt = dmAddr_r;
    dmWdata_nxt = dmWdata_r;
    dmRead_nxt = 1'b0;
    dmWrite_nxt = 1'b0;
    stkWr = 1'b0;
    stkRd = 1'b0;
    case (state_r)
      S_IDLE:
      begin
        if (apbWrite)
        begin
          if (paddr >= OFS_IDX0 && paddr < OFS_PC)
            idx_nxt[idxOfs[3:2]] = pwdata[ADDR_W-1:0];
          case (paddr)
            OFS_CMD:
            begin
              op_nxt = op_e'(pwdata[CMD_OP_LSB +: 3]);
              regA_nxt = pwdata[CMD_RA_LSB +: REG_W];
              regB_nxt = pwdata[CMD_RB_LSB +: REG_W];
              idxSel_nxt = pwdata[CMD_IDX_LSB +: 2];
              am_nxt = am_e'(pwdata[CMD_AM_LSB +: 2]);
              imm_nxt = pwdata[CMD_IMM_LSB +: DATA_W];
              fsel_nxt = pwdata[CMD_F_LSB +: 3];
              sval_nxt = pwdata[CMD_S_BIT];
              g_nxt = pwdata[CMD_G_LSB +: 2];
              rf_nxt = pwdata[CMD_RF_BIT];
              err_nxt = 1'b0;
              taken_nxt = 1'b0;
              state_nxt = S_EXEC;
            end
            OFS_CCR:
            begin
              flags_nxt = pwdata[FLAG_Z +: FLAG_W];
              gie_nxt = pwdata[CCR_GIE_BIT];
              bank_nxt = pwdata[CCR_BANK_LSB +: BANK_W];
            end
            OFS_REGSEL: regSel_nxt = pwdata[REG_W-1:0];
            OFS_REGDATA: regs_nxt[regSel_r] = pwdata[DATA_W-1:0];
            OFS_PC: pc_nxt = pwdata[ADDR_W-1:0];
            OFS_STACK:
            begin
              // call pushes whole environment, then jumps
              stkWr = 1'b1;
              sp_nxt = sp_r + 1'b1;
              pc_nxt = pwdata[ADDR_W-1:0];
            end
            default: ;
          endcase
        end
      end
      S_EXEC:
      begin
        state_nxt = S_IDLE;
        pc_nxt = pc_r + PC_STEP;
        case (op_r)
          OP_MOVE_MR, OP_MOVE_RM:
          begin
            if (am_r == AM_RSVD || (am_r == AM_IMMREL && (op_r == OP_MOVE_MR ? regB_r[4] : regA_r[4])))
              err_nxt = 1'b1;
            else
            begin
              // load / store through indexed, register-relative or immediate-relative mode
              dmAddr_nxt = ea;
              dmWdata_nxt = regs_r[regA_r];
              dmRead_nxt = (op_r == OP_MOVE_MR);
              dmWrite_nxt = (op_r == OP_MOVE_RM);
              pc_nxt = pc_r;
              state_nxt = S_MEM;
            end
          end
          OP_MOVE_RR: regs_nxt[regB_r] = regs_r[regA_r];
          OP_OR_IMM:
          begin
            // limited target, only N and Z
            if (regA_r[4])
              err_nxt = 1'b1;
            else
            begin
              regs_nxt[regA_r] = orRes;
              flags_nxt[FLAG_N] = orRes[DATA_W-1];
              flags_nxt[FLAG_Z] = (orRes == '0);
            end
          end
          OP_ORA_R, OP_ORA_M:
          begin
            // accumulator OR to register or indexed memory
            flags_nxt[FLAG_N] = orRes[DATA_W-1];
            flags_nxt[FLAG_Z] = (orRes == '0);
            if (op_r == OP_ORA_R)
              regs_nxt[regB_r] = orRes;
            else
            begin
              dmAddr_nxt = idx_r[idxSel_r];
              dmWdata_nxt = orRes;
              dmWrite_nxt = 1'b1;
              pc_nxt = pc_r;
              state_nxt = S_MEM;
            end
          end
          OP_CONDITIONAL_RETURN_OP:
          begin
            if (cond && sp_r != '0)
            begin
              stkRd = 1'b1;
              pc_nxt = pc_r;
              state_nxt = S_POP;
            end
            else
              err_nxt = cond;
          end
          default: ;
        endcase
      end
      S_MEM:
      begin
        // request held until the memory acknowledges
        dmRead_nxt = dmRead_r & ~dmAck;
        dmWrite_nxt = dmWrite_r & ~dmAck;
        if (dmAck)
        begin
          if (dmRead_r)
            regs_nxt[regB_r] = dmRdata;
          pc_nxt = pc_r + PC_STEP;
          state_nxt = S_IDLE;
        end
      end
      S_POP:
      begin
        pc_nxt = stkQ[STK_PC_LSB +: ADDR_W];
        sp_nxt = spDec;
        taken_nxt = 1'b1;
        case (g_r)
          G_RESTORE: gie_nxt = stkQ[STK_GIE_BIT];
          G_SET: gie_nxt = 1'b1;
          G_CLEAR: gie_nxt = 1'b0;
          default: gie_nxt = gie_r;
        endcase
        if (rf_r)
        begin
          flags_nxt = stkQ[STK_FLAG_LSB +: FLAG_W];
          bank_nxt = stkQ[STK_BANK_LSB +: BANK_W];
        end
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= S_IDLE;
      op_r <= OP_NOP;
      am_r <= AM_INDEXED;
      regA_r <= '0;
      regB_r <= '0;
      regSel_r <= '0;
      idxSel_r <= '0;
      imm_r <= '0;
      fsel_r <= '0;
      sval_r <= 1'b0;
      g_r <= G_KEEP;
      rf_r <= 1'b0;
      err_r <= 1'b0;
      taken_r <= 1'b0;
      flags_r <= FLAGS_RESET;
      gie_r <= 1'b0;
      bank_r <= BANK_RESET;
      pc_r <= '0;
      sp_r <= '0;
      for (int i = 0; i < NUM_IDX; i++)
        idx_r[i] <= '0;
      for (int i = 0; i < NUM_REGS; i++)
        regs_r[i] <= '0;
      dmAddr_r <= '0;
      dmWdata_r <= '0;
      dmRead_r <= 1'b0;
      dmWrite_r <= 1'b0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      am_r <= am_nxt;
      regA_r <= regA_nxt;
      regB_r <= regB_nxt;
      regSel_r <= regSel_nxt;
      idxSel_r <= idxSel_nxt;
      imm_r <= imm_nxt;
      fsel_r <= fsel_nxt;
      sval_r <= sval_nxt;
      g_r <= g_nxt;
      rf_r <= rf_nxt;
      err_r <= err_nxt;
      taken_r <= taken_nxt;
      flags_r <= flags_nxt;
      gie_r <= gie_nxt;
      bank_r <= bank_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      idx_r <= idx_nxt;
      regs_r <= regs_nxt;
      dmAddr_r <= dmAddr_nxt;
      dmWdata_r <= dmWdata_nxt;
      dmRead_r <= dmRead_nxt;
      dmWrite_r <= dmWrite_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dmAddr = dmAddr_r;
  assign dmWdata = dmWdata_r;
  assign dmRead = dmRead_r;
  assign dmWrite = dmWrite_r;
  assign globalInterruptEnable = gie_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  chk_move_keeps_flags: assert property ((state_r == S_EXEC && op_r inside {OP_MOVE_MR, OP_MOVE_RM, OP_MOVE_RR})
    |=> flags_r == $past(flags_r) [*2]) else $error("move changed flags");
  chk_regrel_addr: assert property ((state_r == S_EXEC && op_r == OP_MOVE_MR && am_r == AM_REGREL)
    |=> dmRead && dmAddr == 16'($past(idx_r[idxSel_r]) + {8'h00, $past(acc)})) else $error("bad rel address");
  chk_immrel_addr: assert property ((state_r == S_EXEC && op_r == OP_MOVE_RM && am_r == AM_IMMREL && !regA_r[4])
    |=> dmWrite && dmAddr == 16'($past(idx_r[IZ_SEL]) + {8'h00, $past(imm_r)})) else $error("bad imm address");
  chk_limited_load: assert property ((state_r == S_EXEC && op_r == OP_MOVE_MR && am_r == AM_IMMREL && regB_r[4])
    |=> !dmRead && err_r && state_r == S_IDLE) else $error("high register accepted");
  chk_or_imm_flags: assert property ((state_r == S_EXEC && op_r == OP_OR_IMM)
    |=> flags_r[FLAG_C] == $past(flags_r[FLAG_C]) && flags_r[FLAG_V] == $past(flags_r[FLAG_V])) else $error("C or V hit");
  chk_ret_not_taken: assert property ((state_r == S_EXEC && op_r == OP_CONDITIONAL_RETURN_OP && !cond)
    |=> sp_r == $past(sp_r) && gie_r == $past(gie_r) && bank_r == $past(bank_r)
    && pc_r == 16'($past(pc_r) + PC_STEP)) else $error("untaken return changed state");
  chk_ret_pops: assert property ((state_r == S_EXEC && op_r == OP_CONDITIONAL_RETURN_OP && cond && sp_r != '0)
    |-> ##2 sp_r == $past(sp_r, 2) - 1'b1 && taken_r) else $error("return did not pop");
  chk_gie_set: assert property ((state_r == S_POP && g_r == G_SET) |=> gie_r)
    else $error("enable not set");
  chk_gie_clear: assert property ((state_r == S_POP && g_r == G_CLEAR) |=> !gie_r)
    else $error("enable not cleared");
  chk_rf_restore: assert property ((state_r == S_POP && rf_r)
    |=> flags_r == $past(stkQ[STK_FLAG_LSB +: FLAG_W])) else $error("flags not restored");
endmodule // move_or_condreturn_exec

// File: testbench/data_mem_model.sv
`timescale 1ns/100ps
module data_mem_model import move_or_pkg::*; (
  input wire logic ref_clk,
  input wire logic [ADDR_W-1:0] dmAddr,
  input wire logic [DATA_W-1:0] dmWdata,
  input wire logic dmRead,
  input wire logic dmWrite,
  input wire logic [3:0] waitCycles,
  output logic [DATA_W-1:0] dmRdata,
  output logic dmAck
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [3:0] cnt;
  initial
  begin
    dmAck = 1'b0;
    dmRdata = 8'h00;
    cnt = 4'h0;
    foreach (mem[i]) mem[i] = 8'hEE;
  end
  // slow answers count out waitCycles first
  always @(posedge ref_clk)
  begin
    if (dmAck || !(dmRead || dmWrite))
    begin
      dmAck <= 1'b0;
      cnt <= 4'h0;
      // released bus must not look like a valid byte
      dmRdata <= ~dmRdata;
    end
    else if (cnt < waitCycles)
      cnt <= cnt + 4'h1;
    else
    begin
      dmAck <= 1'b1;
      if (dmRead) dmRdata <= mem[dmAddr];
      if (dmWrite) mem[dmAddr] <= dmWdata;
    end
  end
endmodule // data_mem_model

// File: testbench/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb import move_or_pkg::*; ;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, dmRead, dmWrite, dmAck, globalInterruptEnable, rdErr;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [ADDR_W-1:0] dmAddr;
  logic [DATA_W-1:0] dmWdata, dmRdata;
  logic [7:0] trxStatus;
  logic [3:0] memWait;
  int n_errors = 0;
  int checks = 0;
  move_or_condreturn_exec move_or_condreturn_exec_inst (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dmAddr(dmAddr), .dmWdata(dmWdata), .dmRead(dmRead), .dmWrite(dmWrite),
    .dmRdata(dmRdata), .dmAck(dmAck), .trxStatus(trxStatus), .globalInterruptEnable(globalInterruptEnable));
  data_mem_model data_mem_model_inst (.ref_clk(ref_clk), .dmAddr(dmAddr), .dmWdata(dmWdata), .dmRead(dmRead),
    .dmWrite(dmWrite), .waitCycles(memWait), .dmRdata(dmRdata), .dmAck(dmAck));
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++k < 20);
    if (k >= 20)
    begin
      n_errors++;
      complete_run();
    end
    else
    begin
      rdVal = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task automatic rd(input logic [PADDR_W-1:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic run(input logic [31:0] c);
    int k;
    wr(OFS_CMD, c);
    k = 0;
    do rd(OFS_STATUS); while (rdVal[ST_BUSY_BIT] !== 1'b0 && ++k < 40);
    if (k >= 40)
    begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic setReg(input logic [4:0] r, input logic [7:0] v);
    wr(OFS_REGSEL, {27'h0, r});
    wr(OFS_REGDATA, {24'h0, v});
  endtask
  task automatic getReg(input logic [4:0] r);
    wr(OFS_REGSEL, {27'h0, r});
    rd(OFS_REGDATA);
  endtask
  function automatic logic [31:0] cmd(op_e op, logic [4:0] ra, logic [4:0] rb, logic [1:0] ix, am_e am,
    logic [7:0] imm, logic [2:0] f = 3'h0, logic s = 1'b0, logic [1:0] g = 2'h0, logic rf = 1'b0);
    return {rf, g, s, f, imm, am, ix, rb, ra, op};
  endfunction
  task automatic t_reset();
    rd(12'h0FC);
    `CHK({rdErr, rdVal}, 33'h100000000)
    // true condition on an empty stack: refused, nothing popped
    run(cmd(OP_CONDITIONAL_RETURN_OP, 5'd0, 5'd0, 2'd0, AM_INDEXED, 8'h00, F_Z, 1'b0, G_SET, 1'b1));
    `CHK({rdVal[ST_TAKEN_BIT], rdVal[ST_ERR_BIT], rdVal[ST_SP_LSB +: 8]}, 10'h100)
    `CHK(globalInterruptEnable, 1'b0)
  endtask
  task automatic t_load();
    memWait <= 4'h3;
    wr(OFS_CCR, 32'h2A);
    setReg(5'd16, 8'hF5);
    wr(OFS_IDX0 + 12'h004, 32'hFF20);
    data_mem_model_inst.mem[16'h0015] = 8'h3C;
    run(cmd(OP_MOVE_MR, 5'd0, 5'd7, 2'd1, AM_REGREL, 8'h00));
    getReg(5'd7);
    `CHK(rdVal, 32'h3C)
    rd(OFS_CCR);
    `CHK(rdVal, 32'h2A)
  endtask
  task automatic t_immrel();
    memWait <= 4'h0;
    wr(OFS_IDX0 + 12'h00C, 32'h1234);
    data_mem_model_inst.mem[16'h1333] = 8'h77;
    run(cmd(OP_MOVE_MR, 5'd0, 5'd15, 2'd3, AM_IMMREL, 8'hFF));
    getReg(5'd15);
    `CHK(rdVal, 32'h77)
    data_mem_model_inst.mem[16'h1234] = 8'h5A;
    run(cmd(OP_MOVE_MR, 5'd0, 5'd20, 2'd3, AM_INDEXED, 8'h00));
    getReg(5'd20);
    `CHK(rdVal, 32'h5A)
    run(cmd(OP_MOVE_MR, 5'd0, 5'd21, 2'd3, AM_RSVD, 8'h00));
    `CHK(rdVal[ST_ERR_BIT], 1'b1)
    run(cmd(OP_MOVE_MR, 5'd0, 5'd16, 2'd3, AM_IMMREL, 8'hFF));
    `CHK(rdVal[ST_ERR_BIT], 1'b1)
    getReg(5'd16);
    `CHK(rdVal, 32'hF5)
    setReg(5'd4, 8'h9D);
    run(cmd(OP_MOVE_RM, 5'd4, 5'd0, 2'd3, AM_IMMREL, 8'h01));
    `CHK(data_mem_model_inst.mem[16'h1235], 8'h9D)
    run(cmd(OP_MOVE_RR, 5'd4, 5'd30, 2'd0, AM_INDEXED, 8'h00));
    getReg(5'd30);
    `CHK(rdVal, 32'h9D)
    run(cmd(OP_MOVE_RM, 5'd17, 5'd0, 2'd3, AM_IMMREL, 8'h02));
    `CHK({rdVal[ST_ERR_BIT], data_mem_model_inst.mem[16'h1236]}, 9'h1EE)
  endtask
  task automatic t_or();
    wr(OFS_CCR, 32'h06);
    setReg(5'd2, 8'h80);
    run(cmd(OP_OR_IMM, 5'd2, 5'd0, 2'd0, AM_INDEXED, 8'h01));
    getReg(5'd2);
    `CHK(rdVal, 32'h81)
    rd(OFS_CCR);
    `CHK(rdVal, 32'h0E)
    run(cmd(OP_OR_IMM, 5'd18, 5'd0, 2'd0, AM_INDEXED, 8'h01));
    `CHK(rdVal[ST_ERR_BIT], 1'b1)
    setReg(5'd0, 8'h00);
    setReg(5'd3, 8'h00);
    run(cmd(OP_ORA_R, 5'd3, 5'd9, 2'd0, AM_INDEXED, 8'h00));
    rd(OFS_CCR);
    `CHK(rdVal, 32'h07)
    setReg(5'd0, 8'h40);
    setReg(5'd3, 8'h02);
    wr(OFS_IDX0 + 12'h008, 32'h0200);
    run(cmd(OP_ORA_M, 5'd3, 5'd0, 2'd2, AM_INDEXED, 8'h00));
    `CHK(data_mem_model_inst.mem[16'h0200], 8'h42)
  endtask
  task automatic t_ret();
    logic [6:0] y;
    logic [1:0] g;
    logic global_interrupt_enable;
    for (int f = 0; f < 8; f++)
    begin
      g = f[1:0];
      global_interrupt_enable = (g != 2'd3);
      y = {2'b00, (g == 2'd0 || g == 2'd3), 4'(f < 4 ? 1 << f : 0)};
      trxStatus <= (f < 4) ? 8'h00 : 8'(1 << (f - 4));
      wr(OFS_PC, 32'h0040 + f);
      wr(OFS_CCR, 32'h5F);
      wr(OFS_STACK, 32'h0500);
      wr(OFS_CCR, {25'h0, y});
      run(cmd(OP_CONDITIONAL_RETURN_OP, 5'd0, 5'd0, 2'd0, AM_INDEXED, 8'h00, f[2:0], 1'b0, g, f[2]));
      `CHK(rdVal[ST_SP_LSB +: 8], 8'h01)
      rd(OFS_PC);
      `CHK(rdVal, 32'h0501)
      rd(OFS_CCR);
      `CHK(rdVal, {25'h0, y})
      run(cmd(OP_CONDITIONAL_RETURN_OP, 5'd0, 5'd0, 2'd0, AM_INDEXED, 8'h00, f[2:0], 1'b1, g, f[2]));
      `CHK({rdVal[ST_TAKEN_BIT], rdVal[ST_SP_LSB +: 8]}, 9'h100)
      rd(OFS_PC);
      `CHK(rdVal, 32'h0040 + f)
      rd(OFS_CCR);
      `CHK(rdVal, {25'h0, f[2] ? 2'b10 : 2'b00, global_interrupt_enable, f[2] ? 4'hF : y[3:0]})
      `CHK(globalInterruptEnable, global_interrupt_enable)
    end
  endtask
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    trxStatus = 8'h00;
    memWait = 4'h0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_load();
    t_immrel();
    t_or();
    t_ret();
    complete_run();
  end
  // hang guard
  initial
  begin
    #1000000;
    n_errors++;
    complete_run();
  end
endmodule // tb
